/* logic/timer_pkg.sv */
// Overview of operation
// - Transfer engine runs while transfer control bit 0 is one, stops when zero.
// - Current transfer pointer reads back; samples moved equal (pointer-start)/4.
// - Start address keeps its lower 15 bits; software aligns it to 4 bytes.
// - End address is exclusive, lower 15 bits, aligned to 4 bytes by software.
// - Counter counts up on the system clock over intervals up to 2^26 cycles.
// - Timing mode sets cycle-end flag when count reaches final; write 1 clears.
// - Force-clear holds count, queue and flags cleared until software releases it.
// - Edge counting counts chosen edges, wraps to 0 at final and flags cycle end.
// - PWM output idles at the polarity level and is opposite while active.
// - Each duty value lasts 1, 4, 8 or 16 periods before the next is taken.
// - Active duration resolves to one clock; new duty values enter while running.
// - Duty equals queued value over final count: 0 gives 0%, final gives 100%.
// - A finished PWM period sets both data-event and cycle-end flags and may interrupt.
// - The transfer engine serves PWM loading and capture storing on timers one, two.
// - Edge field: 00 off, 01 any edge, 10 falling to falling, 11 rising to rising.
// - Any-edge capture marks bit 25 one for high level, zero for low level.
// - Period capture clears bit 25 normally and sets it on a timed-out period.
// - Unchanged input for the timeout count flags timeout and emits a bit-25 sample.
// - The capture input is sampled each clock and widths count in clocks.
// - Each sample sets data-event flag and goes to queue or memory buffer.
// - Capture begins only after force-clear is released; configure before that.
// - Any write to the final count register resets the current count to 0.
// - With wrap enabled the pointer returns to start on reaching the end.
// - The sample queue holds at most eight entries; its count reads back.
package timer_pkg;
  localparam logic [4:0]  IDX_MODE  = 5'h00;
  localparam logic [4:0]  IDX_XFER  = 5'h01;
  localparam logic [4:0]  IDX_IEN   = 5'h02;
  localparam logic [4:0]  IDX_FLAG  = 5'h06;
  localparam logic [4:0]  IDX_QCNT  = 5'h07;
  localparam logic [4:0]  IDX_COUNT = 5'h08;
  localparam logic [4:0]  IDX_FINAL = 5'h0C;
  localparam logic [4:0]  IDX_QUEUE = 5'h10;
  localparam logic [4:0]  IDX_NOW   = 5'h14;
  localparam logic [4:0]  IDX_BEG   = 5'h18;
  localparam logic [4:0]  IDX_END   = 5'h1C;
  localparam logic [7:0]  MODE_RESET = 8'h02;
  localparam int          CNT_W     = 26;
  localparam int          ADDR_W    = 15;
  localparam int          QDEPTH    = 8;
  localparam int          SAMPLE_HI = 25;
  localparam logic [3:0]  QCNT_MAX  = 4'h8;
  localparam logic [3:0]  QCNT_LOW  = 4'h7;
  localparam logic [3:0]  QCNT_HALF = 4'h4;
  localparam int          F_CYC     = 0;
  localparam int          F_DATA    = 1;
  localparam int          F_HF      = 2;
  localparam int          F_DEND    = 3;
  localparam int          F_OV      = 4;
  localparam int          XF_EN     = 0;
  localparam int          XF_WRAP   = 2;
  localparam logic [14:0] WORD_STEP = 15'h0004;
  localparam logic [1:0]  EDGE_OFF  = 2'b00;
  localparam logic [1:0]  EDGE_ANY  = 2'b01;
  localparam logic [1:0]  EDGE_FALL = 2'b10;
  localparam logic [1:0]  EDGE_RISE = 2'b11;
  localparam logic [3:0]  REP_1     = 4'h0;
  localparam logic [3:0]  REP_4     = 4'h3;
  localparam logic [3:0]  REP_8     = 4'h7;
  localparam logic [3:0]  REP_16    = 4'hF;

  typedef struct packed {
    logic [1:0] edge_rep;
    logic       rsvd;
    logic       sub_polar;
    logic       out_en;
    logic       cnt_en;
    logic       clear;
    logic       mode_in;
  } mode_t;

  typedef enum logic [2:0] {
    XF_IDLE  = 3'b001,
    XF_READ  = 3'b010,
    XF_WRITE = 3'b100
  } xfer_state_t;
endpackage

/* logic/timer_pwm_capture_dma.sv */
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module timer_pwm_capture_dma (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [6:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic      [14:0] mem_address_o,
  output logic             mem_read_o,
  output logic             mem_write_o,
  output logic      [31:0] mem_writedata_o,
  input  wire logic [31:0] mem_readdata_i,
  input  wire logic        mem_waitrequest_i,
  input  wire logic        pin_i,
  output logic             pin_o,
  output logic             pin_oe_o,
  output logic             irq_o
);
  localparam int CW = timer_pkg::CNT_W;
  localparam int AW = timer_pkg::ADDR_W;

  timer_pkg::mode_t       mode_q;
  timer_pkg::xfer_state_t st_q;
  logic          ack_q;
  logic [31:0]   rdata_q;
  logic          xen_q;
  logic          wrap_q;
  logic [4:0]    ien_q;
  logic [4:0]    flags_q;
  logic [CW-1:0] final_q;
  logic [CW-1:0] count_q;
  logic [AW-1:0] beg_q;
  logic [AW-1:0] end_q;
  logic [AW-1:0] now_q;
  logic          done_q;
  logic          pend_q;
  logic [CW-1:0] pend_data_q;
  logic          pin_s1_q;
  logic          pin_s2_q;
  logic          pin_prev_q;
  logic [CW-1:0] q_mem [timer_pkg::QDEPTH];
  logic [2:0]    wp_q;
  logic [2:0]    rp_q;
  logic [3:0]    qcnt_q;
  logic [CW-1:0] duty_q;
  logic [3:0]    rep_q;
  logic          pin_q;

  logic          req;
  logic          wr;
  logic          rd;
  logic [4:0]    idx;
  logic [31:0]   rmux;
  logic          run;
  logic          capture;
  logic          evcount;
  logic          pwm;
  logic [CW-1:0] cnt_nxt;
  logic          last;
  logic          rise;
  logic          fall;
  logic          edge_ev;
  logic          timeout;
  logic          sample_ev;
  logic [CW-1:0] sample;
  logic          period_end;
  logic [3:0]    rep_target;
  logic          reload;
  logic          push;
  logic [CW-1:0] push_data;
  logic          pop;
  logic          q_full;
  logic          push_ok;
  logic          mem_done;
  logic [AW-1:0] ptr_nxt;
  logic          ptr_end;
  logic          cap_drop;
  logic [4:0]    set;
  logic [4:0]    clr;

  // Avalon slave: every access is held off exactly one cycle so that read
  // data come from a flop and side effects happen at the accepting edge.
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;
  assign wr  = avs_write_i & ack_q & (|avs_byteenable_i);
  assign rd  = avs_read_i & ack_q;
  assign idx = avs_address_i[6:2];
  assign avs_readdata_o = rdata_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_comb begin
    rmux = 32'h0000_0000;
    case (idx)
      timer_pkg::IDX_MODE:  rmux[7:0] = mode_q & 8'hDF;
      timer_pkg::IDX_XFER:  rmux[2:0] = {wrap_q, 1'b0, xen_q};
      timer_pkg::IDX_IEN:   rmux[4:0] = ien_q;
      timer_pkg::IDX_FLAG:  rmux[4:0] = flags_q;
      timer_pkg::IDX_QCNT:  rmux[3:0] = qcnt_q;
      timer_pkg::IDX_COUNT: rmux[CW-1:0] = count_q;
      timer_pkg::IDX_FINAL: rmux[CW-1:0] = final_q;
      timer_pkg::IDX_QUEUE: rmux[CW-1:0] = q_mem[rp_q];
      timer_pkg::IDX_NOW:   rmux[AW-1:0] = now_q;
      timer_pkg::IDX_BEG:   rmux[AW-1:0] = beg_q;
      timer_pkg::IDX_END:   rmux[AW-1:0] = end_q;
      default:              rmux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i & ~ack_q) begin
      rdata_q <= rmux;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_q <= timer_pkg::MODE_RESET;
      xen_q  <= 1'b0;
      wrap_q <= 1'b0;
      ien_q  <= 5'h00;
    end else if (wr) begin
      case (idx)
        timer_pkg::IDX_MODE: mode_q <= avs_writedata_i[7:0] & 8'hDF;
        timer_pkg::IDX_XFER: begin
          xen_q  <= avs_writedata_i[timer_pkg::XF_EN];
          wrap_q <= avs_writedata_i[timer_pkg::XF_WRAP];
        end
        timer_pkg::IDX_IEN:  ien_q <= avs_writedata_i[4:0];
        default: ;
      endcase
    end
  end

  // Only the low 15 address bits are kept; alignment is up to software.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      final_q <= '0;
      beg_q   <= '0;
      end_q   <= '0;
    end else if (wr) begin
      case (idx)
        timer_pkg::IDX_FINAL: final_q <= avs_writedata_i[CW-1:0];
        timer_pkg::IDX_BEG:   beg_q <= avs_writedata_i[AW-1:0];
        timer_pkg::IDX_END:   end_q <= avs_writedata_i[AW-1:0];
        default: ;
      endcase
    end
  end

  // Two-flop synchroniser; the pin is looked at once per clock.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_s1_q   <= 1'b0;
      pin_s2_q   <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_s1_q   <= pin_i;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  assign rise = pin_s2_q & ~pin_prev_q;
  assign fall = ~pin_s2_q & pin_prev_q;
  assign run  = mode_q.cnt_en & ~mode_q.clear;
  assign capture = mode_q.mode_in & ~mode_q.sub_polar;
  assign evcount = mode_q.mode_in & mode_q.sub_polar;
  assign pwm     = ~mode_q.mode_in & mode_q.out_en;

  always_comb begin
    case (mode_q.edge_rep)
      timer_pkg::EDGE_ANY:  edge_ev = rise | fall;
      timer_pkg::EDGE_FALL: edge_ev = fall;
      timer_pkg::EDGE_RISE: edge_ev = rise;
      default:              edge_ev = 1'b0;
    endcase
  end

  // A final count of zero is treated as a one-cycle period.
  assign cnt_nxt = count_q + 26'h000_0001;
  assign last    = (cnt_nxt == final_q) | (final_q == '0);
  assign timeout = capture & run & last &
                   (mode_q.edge_rep != timer_pkg::EDGE_OFF);
  assign sample_ev = capture & run & (edge_ev | timeout);
  assign period_end = run & ~mode_q.mode_in & last;

  always_comb begin
    sample = cnt_nxt;
    if (mode_q.edge_rep == timer_pkg::EDGE_ANY) begin
      sample[timer_pkg::SAMPLE_HI] = pin_prev_q;
    end else begin
      sample[timer_pkg::SAMPLE_HI] = ~edge_ev;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i | mode_q.clear) begin
      count_q <= '0;
    end else if (wr & (idx == timer_pkg::IDX_FINAL)) begin
      count_q <= '0;
    end else if (run) begin
      if (~mode_q.mode_in) begin
        count_q <= last ? '0 : cnt_nxt;
      end else if (evcount) begin
        if (edge_ev) begin
          count_q <= last ? '0 : cnt_nxt;
        end
      end else if (sample_ev) begin
        count_q <= '0;
      end else begin
        count_q <= cnt_nxt;
      end
    end
  end

  always_comb begin
    case (mode_q.edge_rep)
      2'b01:   rep_target = timer_pkg::REP_4;
      2'b10:   rep_target = timer_pkg::REP_8;
      2'b11:   rep_target = timer_pkg::REP_16;
      default: rep_target = timer_pkg::REP_1;
    endcase
  end

  assign reload = pwm & period_end & (rep_q == rep_target);

  // Queue pushes come from the memory engine, capture or the bus, in that
  // order; a bus write that collides with another push is lost.
  assign mem_done = ~mem_waitrequest_i & (st_q != timer_pkg::XF_IDLE);
  assign pop  = (rd & (idx == timer_pkg::IDX_QUEUE)) |
                (reload & (qcnt_q != 4'h0));
  assign q_full  = (qcnt_q == timer_pkg::QCNT_MAX);

  always_comb begin
    push = 1'b1;
    push_data = avs_writedata_i[CW-1:0];
    if ((st_q == timer_pkg::XF_READ) & mem_done) begin
      push_data = mem_readdata_i[CW-1:0];
    end else if (sample_ev & ~xen_q) begin
      push_data = sample;
    end else if (~(wr & (idx == timer_pkg::IDX_QUEUE))) begin
      push = 1'b0;
    end
  end

  assign push_ok = push & (~q_full | pop);

  always_ff @(posedge ref_clk_i) begin
    if (push_ok) begin
      q_mem[wp_q] <= push_data;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i | mode_q.clear) begin
      wp_q   <= 3'h0;
      rp_q   <= 3'h0;
      qcnt_q <= 4'h0;
    end else begin
      if (push_ok) begin
        wp_q <= wp_q + 3'h1;
      end
      if (pop & (qcnt_q != 4'h0)) begin
        rp_q <= rp_q + 3'h1;
      end
      qcnt_q <= qcnt_q + {3'h0, push_ok}
                - {3'h0, pop & (qcnt_q != 4'h0)};
    end
  end

  // New duty values take effect only at a period boundary, so the output
  // never glitches mid-period.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i | mode_q.clear) begin
      duty_q <= '0;
      rep_q  <= 4'h0;
    end else if (pwm & period_end) begin
      if (rep_q == rep_target) begin
        rep_q <= 4'h0;
        if (qcnt_q != 4'h0) begin
          duty_q <= q_mem[rp_q];
        end
      end else begin
        rep_q <= rep_q + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= mode_q.sub_polar ^ (run & (count_q < duty_q));
    end
  end

  assign pin_o    = pin_q;
  assign pin_oe_o = pwm;

  // Transfer engine, present on timers one and two only.
  localparam logic [14:0] WORD_STEP_C = timer_pkg::WORD_STEP;
  assign ptr_nxt = now_q + WORD_STEP_C;
  assign ptr_end = (ptr_nxt == end_q);
  assign cap_drop = sample_ev & xen_q & pend_q &
                    ~((st_q == timer_pkg::XF_WRITE) & mem_done);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_q <= timer_pkg::XF_IDLE;
    end else begin
      case (st_q)
        timer_pkg::XF_IDLE: begin
          if (xen_q & run & ~done_q) begin
            if (capture & pend_q) begin
              st_q <= timer_pkg::XF_WRITE;
            end else if (pwm & (qcnt_q < timer_pkg::QCNT_LOW)) begin
              st_q <= timer_pkg::XF_READ;
            end
          end
        end
        timer_pkg::XF_READ,
        timer_pkg::XF_WRITE: begin
          if (~mem_waitrequest_i) begin
            st_q <= timer_pkg::XF_IDLE;
          end
        end
        default: st_q <= timer_pkg::XF_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      now_q  <= '0;
      done_q <= 1'b0;
    end else if (~xen_q) begin
      now_q  <= beg_q;
      done_q <= 1'b0;
    end else if (mem_done) begin
      if (ptr_end & wrap_q) begin
        now_q <= beg_q;
      end else begin
        now_q  <= ptr_nxt;
        done_q <= ptr_end;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i | mode_q.clear) begin
      pend_q      <= 1'b0;
      pend_data_q <= '0;
    end else if (sample_ev & xen_q & ~cap_drop) begin
      pend_q      <= 1'b1;
      pend_data_q <= sample;
    end else if ((st_q == timer_pkg::XF_WRITE) & mem_done) begin
      pend_q <= 1'b0;
    end
  end

  assign mem_address_o   = now_q;
  assign mem_read_o      = (st_q == timer_pkg::XF_READ);
  assign mem_write_o     = (st_q == timer_pkg::XF_WRITE);
  assign mem_writedata_o = {6'h00, pend_data_q};

  always_comb begin
    set = 5'h00;
    set[timer_pkg::F_CYC] = period_end | timeout |
                            (run & evcount & edge_ev & last);
    set[timer_pkg::F_DATA] = sample_ev | (pwm & period_end);
    set[timer_pkg::F_HF] = run & (capture ? (qcnt_q >= timer_pkg::QCNT_HALF)
                           : (pwm & (qcnt_q < timer_pkg::QCNT_HALF)));
    set[timer_pkg::F_DEND] = mem_done & ptr_end;
    set[timer_pkg::F_OV] = cap_drop | (push & ~push_ok) |
                           (reload & (qcnt_q == 4'h0));
    clr = (wr & (idx == timer_pkg::IDX_FLAG)) ? avs_writedata_i[4:0] : 5'h00;
  end

  // A flag set in the same cycle as its clear stays set.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i | mode_q.clear) begin
      flags_q <= 5'h00;
    end else begin
      flags_q <= (flags_q & ~clr) | set;
    end
  end

  assign irq_o = |(flags_q & ien_q);

  AST_ACCEPT_ONE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    req & avs_waitrequest_o |=> ~avs_waitrequest_o)
    else $error("Access not accepted after one wait cycle.");
  AST_XFER_STOP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ~xen_q & (st_q == timer_pkg::XF_IDLE) |=> (st_q == timer_pkg::XF_IDLE))
    else $error("Transfer engine started while disabled.");
  AST_PTR_STEP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    xen_q & mem_done & ~ptr_end |=> now_q == $past(now_q) + WORD_STEP_C)
    else $error("Pointer did not step one word.");
  AST_PTR_WRAP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    xen_q & mem_done & ptr_end & wrap_q |=> (now_q == $past(beg_q)) &
    flags_q[timer_pkg::F_DEND])
    else $error("Pointer did not wrap to start.");
  AST_CLEAR_ALL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    mode_q.clear |=> (count_q == '0) && (qcnt_q == 4'h0) && (flags_q == 5'h00))
    else $error("Force clear left state behind.");
  AST_FINAL_WR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wr & (idx == timer_pkg::IDX_FINAL) |=> count_q == '0)
    else $error("Final count write did not zero the count.");
  AST_CYC_END: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    period_end & ~mode_q.clear |=> flags_q[timer_pkg::F_CYC] & (count_q == '0))
    else $error("Period end not flagged.");
  AST_QUEUE_MAX: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (qcnt_q == timer_pkg::QCNT_MAX) & ~pop & ~mode_q.clear |=>
    qcnt_q == timer_pkg::QCNT_MAX)
    else $error("Queue grew past eight.");
  AST_PWM_ZERO: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (duty_q == '0) & $stable(mode_q) ##1 (duty_q == '0) |=>
    pin_o == $past(mode_q.sub_polar))
    else $error("Zero duty left the idle level.");
  AST_PWM_ACTIVE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    run & (count_q < duty_q) & $stable(mode_q) |=>
    pin_o != $past(mode_q.sub_polar))
    else $error("Active level missing inside duty.");
  AST_SAMPLE_FLAG: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    sample_ev & ~mode_q.clear |=> flags_q[timer_pkg::F_DATA])
    else $error("Captured sample did not flag data.");
  AST_PERIOD_B25: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    sample_ev & ~xen_q & ~q_full & (mode_q.edge_rep == timer_pkg::EDGE_RISE)
    & (qcnt_q == 4'h0) |=> q_mem[rp_q][timer_pkg::SAMPLE_HI] == $past(timeout))
    else $error("Period sample marked wrongly.");
endmodule

/* tb/mem_model.sv */
`timescale 1ns/10ps
module mem_model (
  input  wire logic        clk_i,
  input  wire logic [14:0] address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [1:0]  stall_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o
);
  logic [31:0] mem_q [0:255];
  logic [1:0]  cnt_q;
  logic [31:0] pat_q;
  logic        take;

  // Stalls each request for stall_i cycles before accepting it.
  assign take          = (read_i | write_i) & (cnt_q == stall_i);
  assign waitrequest_o = ~take;
  // Outside an accepting cycle the data bus churns so stale reads show up.
  assign readdata_o    = (take & read_i) ? mem_q[address_i[9:2]] : pat_q;

  initial begin
    cnt_q = 2'h0;
    pat_q = 32'h5A5A_A5A5;
    for (int i = 0; i < 256; i++) begin
      mem_q[i] = 32'hFFFF_FFFF;
    end
  end

  always @(posedge clk_i) begin
    pat_q <= ~pat_q;
    if (read_i | write_i) begin
      cnt_q <= take ? 2'h0 : cnt_q + 2'h1;
    end
    if (take & write_i) begin
      mem_q[address_i[9:2]] <= writedata_i;
    end
  end
endmodule

/* tb/tb_timer_pwm_capture_dma.sv */
`timescale 1ns/10ps
module tb_timer_pwm_capture_dma;
  typedef struct packed {
    logic        wr;
    logic [6:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } row_t;

  logic        ref_clk_i, rst_i, rd, wr, pin, mrd, mwr, mwait, irq, pout;
  logic        poe;
  logic [6:0]  adr;
  logic [31:0] wdat, rdat, mwdat, mrdat, q;
  logic        wreq;
  logic [14:0] maddr;
  logic [1:0]  stall;
  int          n_fail, comparisons, hi;
  row_t        rows [0:13];

  timer_pwm_capture_dma i_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .mem_address_o(maddr), .mem_read_o(mrd),
    .mem_write_o(mwr), .mem_writedata_o(mwdat), .mem_readdata_i(mrdat),
    .mem_waitrequest_i(mwait), .pin_i(pin), .pin_o(pout),
    .pin_oe_o(poe), .irq_o(irq));

  mem_model i_mem (
    .clk_i(ref_clk_i), .address_i(maddr), .read_i(mrd), .write_i(mwr),
    .writedata_i(mwdat), .stall_i(stall), .readdata_o(mrdat),
    .waitrequest_o(mwait));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One Avalon access; a clock edge passes first so strobes never toggle
  // twice in one time step.
  task automatic bus(input logic w, input logic [6:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int i;
    @(posedge ref_clk_i);
    adr <= a; wdat <= d; wr <= w; rd <= ~w;
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk_i);
      if (wreq === 1'b0) break;
    end
    r = rdat;
    rd <= 1'b0; wr <= 1'b0;
    if (i == 40) begin n_fail++; summarize(); end
  endtask

  task automatic wreg(input logic [6:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask

  task automatic toggle(input int n, input int gap);
    for (int k = 0; k < n; k++) begin
      repeat (gap) @(posedge ref_clk_i);
      pin <= ~pin;
    end
  endtask

  initial begin
    rst_i = 1'b1; rd = 1'b0; wr = 1'b0; adr = 7'h00; wdat = 32'h0;
    pin = 1'b0; stall = 2'h1; n_fail = 0; comparisons = 0;
    rows = '{ '{1'b0, 7'h00, 32'h0, 32'h02}, '{1'b0, 7'h18, 32'h0, 32'h0},
      '{1'b0, 7'h04, 32'h0, 32'h0}, '{1'b0, 7'h1C, 32'h0, 32'h0},
      '{1'b0, 7'h20, 32'h0, 32'h0}, '{1'b1, 7'h60, 32'hFFFC, 32'h0},
      '{1'b0, 7'h60, 32'h0, 32'h7FFC}, '{1'b1, 7'h70, 32'h1FFF0, 32'h0},
      '{1'b0, 7'h70, 32'h0, 32'h7FF0}, '{1'b0, 7'h50, 32'h0, 32'h7FFC},
      '{1'b1, 7'h24, 32'hFFFF_FFFF, 32'h0}, '{1'b0, 7'h24, 32'h0, 32'h0},
      '{1'b1, 7'h00, 32'h22, 32'h0}, '{1'b0, 7'h00, 32'h0, 32'h02} };
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d, q);
      if (!rows[i].wr) chk(q, rows[i].e);
    end
    $display("register table done");

    wreg(7'h30, 32'h5);
    wreg(7'h00, 32'h04);
    repeat (12) @(posedge ref_clk_i);
    wreg(7'h00, 32'h00);
    bus(1'b0, 7'h18, 0, q); chk(q & 32'h1, 32'h1);
    wreg(7'h18, 32'h1F);
    bus(1'b0, 7'h18, 0, q); chk(q, 32'h0);
    wreg(7'h30, 32'h7);
    bus(1'b0, 7'h20, 0, q); chk(q, 32'h0);
    $display("timing done");

    // Rising-edge counting with a final value of three.
    wreg(7'h00, 32'h02);
    wreg(7'h30, 32'h3);
    wreg(7'h00, 32'hD5);
    toggle(4, 4);
    repeat (6) @(posedge ref_clk_i);
    bus(1'b0, 7'h20, 0, q); chk(q, 32'h2);
    bus(1'b0, 7'h18, 0, q); chk(q & 32'h1, 32'h0);
    toggle(2, 4);
    repeat (6) @(posedge ref_clk_i);
    bus(1'b0, 7'h20, 0, q); chk(q, 32'h0);
    bus(1'b0, 7'h18, 0, q); chk(q & 32'h1, 32'h1);
    $display("edge count done");

    for (int p = 0; p < 2; p++) begin
      wreg(7'h00, 32'h02);
      wreg(7'h30, 32'h4);
      wreg(7'h00, 32'h08 | (p << 4));
      // Duty equals the period so the active level must hold throughout.
      for (int k = 0; k < 9 - 8 * p; k++) wreg(7'h40, 32'h4);
      bus(1'b0, 7'h1C, 0, q); chk(q, (p == 0) ? 32'h8 : 32'h1);
      wreg(7'h00, 32'h0C | (p << 4));
      repeat (20) @(posedge ref_clk_i);
      hi = 0;
      for (int k = 0; k < 8; k++) begin
        @(posedge ref_clk_i);
        hi += (pout === 1'b1);
      end
      chk(hi, (p == 0) ? 8 : 0);
      chk(poe, 1'b1);
    end
    $display("pwm done");

    // Any-edge capture into a three-word ring without wrap.
    wreg(7'h00, 32'h02);
    pin <= 1'b0;
    wreg(7'h30, 32'h64);
    wreg(7'h60, 32'h100);
    wreg(7'h70, 32'h10C);
    wreg(7'h04, 32'h01);
    wreg(7'h08, 32'h02);
    wreg(7'h18, 32'h1F);
    wreg(7'h00, 32'h47);
    wreg(7'h00, 32'h45);
    toggle(4, 10);
    repeat (140) @(posedge ref_clk_i);
    bus(1'b0, 7'h50, 0, q); chk(q, 32'h10C);
    bus(1'b0, 7'h18, 0, q); chk(q & 32'hB, 32'hB);
    chk(irq, 1'b1);
    chk(i_mem.mem_q[8'h41], 32'h0200_000A);
    chk(i_mem.mem_q[8'h42], 32'h0000_000A);
    chk(i_mem.mem_q[8'h43], 32'hFFFF_FFFF);
    $display("capture done");

    // One duty value held for a group of four periods, then a zero duty.
    wreg(7'h04, 32'h0);
    wreg(7'h00, 32'h02);
    wreg(7'h30, 32'h4);
    wreg(7'h00, 32'h48);
    wreg(7'h40, 32'h4);
    wreg(7'h40, 32'h0);
    wreg(7'h00, 32'h4C);
    hi = 0;
    for (int k = 0; k < 80; k++) begin
      @(posedge ref_clk_i);
      hi += (pout === 1'b1);
    end
    chk(hi, 16);
    $display("repeat done");
    summarize();
  end
endmodule
